// File: hdl/data_addr_gen.sv
// data address former: index plus signed low byte, page selection by model
// assumes combinational use inside one clock domain
`timescale 1ns/1ns
module data_addr_gen (
	input wire ld_subset_pkg::addr_kind_e kind,
	input wire logic largeMemoryModels,
	input wire logic [15:0] indexX,
	input wire logic [15:0] indexY,
	input wire logic [15:0] plainAddr,
	input wire logic [7:0] lowByte,
	input wire logic [7:0] pageForX,
	input wire logic [7:0] pageForY,
	input wire logic [7:0] generalDataPage,
	output logic [15:0] addr,
	output logic [7:0] page
);
	import ld_subset_pkg::*;
	logic [15:0] offset;
	assign offset = {{8{lowByte[7]}}, lowByte};
	always_comb begin
		unique case (kind)
			DST_IDX_X: begin
				addr = indexX + offset;
				page = largeMemoryModels ? pageForX : RST_BYTE;
			end
			DST_IDX_Y: begin
				addr = indexY + offset;
				page = largeMemoryModels ? pageForY : RST_BYTE;
			end
			default: begin
				addr = plainAddr;
				page = largeMemoryModels ? generalDataPage : RST_BYTE;
			end
		endcase
	end
endmodule

// File: hdl/ld_subset_pkg.sv
// constants and carriers for the load-subset decode and execute block
// assumes a byte-wide fetch stream and a byte-wide data memory write port
package ld_subset_pkg;
	localparam logic [7:0] OP_PREFIX = 8'hCE;
	localparam logic [7:0] OP_LD_R_IMM = 8'hB0;
	localparam logic [7:0] OP_LD_BASE = 8'hB4;
	// second-byte codes, after the prefix, chosen for flag, bank and the data, x and y page loads
	localparam logic [7:0] OP_LD_FLAGS = 8'h9F;
	localparam logic [7:0] OP_LD_BANK_P = 8'hC4;
	localparam logic [7:0] OP_LD_XPAGE_P = 8'hC6;
	localparam logic [7:0] OP_LD_GPAGE_P = 8'hC5;
	localparam logic [7:0] OP_LD_YPAGE_P = 8'hC7;
	localparam logic [7:0] OP_ST_X_LOW = 8'h46;
	localparam logic [7:0] OP_ST_Y_LOW = 8'h47;
	localparam logic [7:0] OP_ST_MASK = 8'hE7;
	localparam int SRC_POS = 3;
	localparam logic [3:0] CYC_LD_R = 4'h2;
	localparam logic [3:0] CYC_LD_BASE = 4'h2;
	localparam logic [3:0] CYC_LD_FLAGS = 4'h3;
	localparam logic [3:0] CYC_LD_BANK = 4'h4;
	localparam logic [3:0] CYC_LD_PAGE = 4'h3;
	localparam logic [3:0] CYC_ST_IDX = 4'h4;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [7:0] RST_FLAGS = 8'hC0;

	typedef enum logic [1:0] {
		DST_IDX_X = 2'b00,
		DST_IDX_Y = 2'b01,
		DST_PLAIN = 2'b11
	} addr_kind_e;

	typedef struct packed {
		logic [7:0] page;
		logic [15:0] addr;
		logic [7:0] data;
	} mem_write_s;

	typedef struct packed {
		logic [7:0] regA;
		logic [7:0] regB;
		logic [7:0] regL;
		logic [7:0] regH;
		logic [15:0] indexX;
		logic [15:0] indexY;
		logic [7:0] baseHighByte;
		logic [7:0] systemFlags;
		logic [7:0] newCodeBank;
		logic [7:0] generalDataPage;
		logic [7:0] pageForX;
		logic [7:0] pageForY;
	} core_regs_s;
endpackage

// File: hdl/load_instr_subset_exec.sv
// decode and execute of the immediate-load and indexed-store subset
// assumes fetch presents one byte per instruction cycle with a valid strobe
`timescale 1ns/1ns
module load_instr_subset_exec (
	input wire logic clk,
	input wire logic reset,
	input wire logic largeMemoryModels,
	input wire logic fetchValid,
	input wire logic [7:0] fetchByte,
	output logic fetchReady,
	output logic memWrite,
	output ld_subset_pkg::mem_write_s memOut,
	output ld_subset_pkg::core_regs_s regsOut,
	output logic instrDone,
	output logic illegalOp
);
	import ld_subset_pkg::*;

	typedef enum logic [2:0] {
		S_OPCODE = 3'b000,
		S_SECOND = 3'b001,
		S_IMM = 3'b011,
		S_EXEC = 3'b010,
		S_WAIT = 3'b110
	} state_e;

	typedef enum logic [3:0] {
		T_NONE, T_LDR, T_BASE, T_FLAGS, T_BANK, T_GPAGE, T_XPAGE, T_YPAGE, T_STX, T_STY
	} target_e;

	state_e state_r;
	target_e target_r;
	logic [1:0] srcSel_r;
	logic [3:0] cycLeft_r;
	logic [7:0] imm_r;
	core_regs_s regs_r;
	logic [7:0] srcData;
	logic [15:0] stAddr;
	logic [7:0] stPage;
	addr_kind_e stKind;
	logic take;
	logic isStore;

	assign fetchReady = (state_r == S_OPCODE) || (state_r == S_SECOND) || (state_r == S_IMM);
	assign take = fetchReady && fetchValid;
	assign isStore = (target_r == T_STX) || (target_r == T_STY);
	assign stKind = (target_r == T_STY) ? DST_IDX_Y : DST_IDX_X;

	always_comb begin
		unique case (srcSel_r)
			2'b00: srcData = regs_r.regA;
			2'b01: srcData = regs_r.regB;
			2'b10: srcData = regs_r.regL;
			default: srcData = regs_r.regH;
		endcase
	end

	// the low byte is always register L, read live at the store cycle
	data_addr_gen u_addr (
		.kind(stKind),
		.largeMemoryModels(largeMemoryModels),
		.indexX(regs_r.indexX),
		.indexY(regs_r.indexY),
		.plainAddr(RST_WORD),
		.lowByte(regs_r.regL),
		.pageForX(regs_r.pageForX),
		.pageForY(regs_r.pageForY),
		.generalDataPage(regs_r.generalDataPage),
		.addr(stAddr),
		.page(stPage)
	);

	// sequencer: cycles counted from opcode fetch; pads keep documented totals
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= S_OPCODE;
			target_r <= T_NONE;
			srcSel_r <= 2'b00;
			cycLeft_r <= 4'h0;
			imm_r <= RST_BYTE;
			illegalOp <= 1'b0;
		end else begin
			illegalOp <= 1'b0;
			unique case (state_r)
				S_OPCODE: if (take) begin
					srcSel_r <= fetchByte[1:0];
					if ((fetchByte & 8'hFC) == OP_LD_R_IMM) begin
						target_r <= T_LDR;
						cycLeft_r <= CYC_LD_R - 4'h1;
						state_r <= S_IMM;
					end else if (fetchByte == OP_LD_BASE) begin
						target_r <= T_BASE;
						cycLeft_r <= CYC_LD_BASE - 4'h1;
						state_r <= S_IMM;
					end else if (fetchByte == OP_PREFIX) begin
						cycLeft_r <= 4'h0;
						state_r <= S_SECOND;
					end else begin
						illegalOp <= 1'b1;
					end
				end
				S_SECOND: if (take) begin
					srcSel_r <= fetchByte[SRC_POS+1:SRC_POS];
					if ((fetchByte & OP_ST_MASK) == OP_ST_X_LOW) begin
						target_r <= T_STX;
						cycLeft_r <= CYC_ST_IDX - 4'h2;
						state_r <= S_WAIT;
					end else if ((fetchByte & OP_ST_MASK) == OP_ST_Y_LOW) begin
						target_r <= T_STY;
						cycLeft_r <= CYC_ST_IDX - 4'h2;
						state_r <= S_WAIT;
					end else if (fetchByte == OP_LD_FLAGS) begin
						target_r <= T_FLAGS;
						cycLeft_r <= CYC_LD_FLAGS - 4'h2;
						state_r <= S_IMM;
					end else if (fetchByte == OP_LD_BANK_P) begin
						target_r <= T_BANK;
						cycLeft_r <= CYC_LD_BANK - 4'h2;
						state_r <= S_IMM;
					end else if (fetchByte == OP_LD_GPAGE_P) begin
						target_r <= T_GPAGE;
						cycLeft_r <= CYC_LD_PAGE - 4'h2;
						state_r <= S_IMM;
					end else if (fetchByte == OP_LD_XPAGE_P) begin
						target_r <= T_XPAGE;
						cycLeft_r <= CYC_LD_PAGE - 4'h2;
						state_r <= S_IMM;
					end else if (fetchByte == OP_LD_YPAGE_P) begin
						target_r <= T_YPAGE;
						cycLeft_r <= CYC_LD_PAGE - 4'h2;
						state_r <= S_IMM;
					end else begin
						illegalOp <= 1'b1;
						state_r <= S_OPCODE;
					end
				end
				S_IMM: if (take) begin
					imm_r <= fetchByte;
					cycLeft_r <= cycLeft_r - 4'h1;
					state_r <= (cycLeft_r == 4'h1) ? S_EXEC : S_WAIT;
				end
				S_WAIT: begin
					cycLeft_r <= cycLeft_r - 4'h1;
					if (cycLeft_r <= 4'h1) begin
						state_r <= S_EXEC;
					end
				end
				S_EXEC: begin
					state_r <= S_OPCODE;
					target_r <= T_NONE;
				end
				default: state_r <= S_OPCODE;
			endcase
		end
	end

	// register writes happen only in the last cycle; flags touched only by the flag load
	always_ff @(posedge clk) begin
		if (reset) begin
			regs_r <= '{RST_BYTE, RST_BYTE, RST_BYTE, RST_BYTE, RST_WORD, RST_WORD, RST_BYTE,
				RST_FLAGS, RST_BYTE, RST_BYTE, RST_BYTE, RST_BYTE};
		end else if (state_r == S_EXEC) begin
			unique case (target_r)
				T_LDR: begin
					unique case (srcSel_r)
						2'b00: regs_r.regA <= imm_r;
						2'b01: regs_r.regB <= imm_r;
						2'b10: regs_r.regL <= imm_r;
						default: regs_r.regH <= imm_r;
					endcase
				end
				T_BASE: regs_r.baseHighByte <= imm_r;
				T_FLAGS: regs_r.systemFlags <= imm_r;
				T_BANK: regs_r.newCodeBank <= imm_r;
				T_GPAGE: regs_r.generalDataPage <= imm_r;
				T_XPAGE: regs_r.pageForX <= imm_r;
				T_YPAGE: regs_r.pageForY <= imm_r;
				default: regs_r <= regs_r;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			memWrite <= 1'b0;
			memOut <= '{RST_BYTE, RST_WORD, RST_BYTE};
			instrDone <= 1'b0;
		end else begin
			memWrite <= (state_r == S_EXEC) && isStore;
			instrDone <= state_r == S_EXEC;
			if ((state_r == S_EXEC) && isStore) begin
				memOut <= '{stPage, stAddr, srcData};
			end
		end
	end

	assign regsOut = regs_r;

	// instruction length counter from opcode acceptance to the S_EXEC cycle
	logic [3:0] len_r;
	always_ff @(posedge clk) begin
		if (reset || (state_r == S_OPCODE)) begin
			len_r <= 4'h1;
		end else begin
			len_r <= len_r + 4'h1;
		end
	end

	property p_st_x_addr;
		@(posedge clk) disable iff (reset)
		(state_r == S_EXEC && target_r == T_STX) |=>
			memWrite && memOut.addr == $past(regs_r.indexX) + {{8{$past(regs_r.regL[7])}},
			$past(regs_r.regL)};
	endproperty
	a_st_x_addr: assert property (p_st_x_addr) else $error("x store address wrong");

	property p_st_x_page;
		@(posedge clk) disable iff (reset)
		(state_r == S_EXEC && target_r == T_STX && largeMemoryModels) |=>
			memOut.page == $past(regs_r.pageForX);
	endproperty
	a_st_x_page: assert property (p_st_x_page) else $error("x store page wrong");

	property p_st_y_page;
		@(posedge clk) disable iff (reset)
		(state_r == S_EXEC && target_r == T_STY) |=>
			memOut.page == ($past(largeMemoryModels) ? $past(regs_r.pageForY) : RST_BYTE);
	endproperty
	a_st_y_page: assert property (p_st_y_page) else $error("y store page wrong");

	property p_decode_stx;
		@(posedge clk) disable iff (reset)
		(state_r == S_SECOND && take && (fetchByte & OP_ST_MASK) == OP_ST_X_LOW)
			|=> target_r == T_STX;
	endproperty
	a_decode_stx: assert property (p_decode_stx) else $error("x store not decoded");

	property p_decode_sty;
		@(posedge clk) disable iff (reset)
		(state_r == S_SECOND && take && (fetchByte & OP_ST_MASK) == OP_ST_Y_LOW)
			|=> target_r == T_STY;
	endproperty
	a_decode_sty: assert property (p_decode_sty) else $error("y store not decoded");

	property p_ldr_value;
		@(posedge clk) disable iff (reset)
		(state_r == S_OPCODE && take && fetchByte == OP_LD_R_IMM) ##1 (take [*1])
			|=> ##1 regs_r.regA == $past(fetchByte, 2);
	endproperty
	a_ldr_value: assert property (p_ldr_value) else $error("A immediate not loaded");

	property p_flags_quiet;
		@(posedge clk) disable iff (reset)
		!(state_r == S_EXEC && target_r == T_FLAGS) |=> $stable(regs_r.systemFlags);
	endproperty
	a_flags_quiet: assert property (p_flags_quiet) else $error("flags changed");

	property p_len_base;
		@(posedge clk) disable iff (reset)
		(state_r == S_EXEC && target_r == T_BASE) |-> len_r == CYC_LD_BASE;
	endproperty
	a_len_base: assert property (p_len_base) else $error("base load length");

	property p_len_flags;
		@(posedge clk) disable iff (reset)
		(state_r == S_EXEC && target_r == T_FLAGS) |-> len_r == CYC_LD_FLAGS;
	endproperty
	a_len_flags: assert property (p_len_flags) else $error("flag load length");

	property p_len_bank;
		@(posedge clk) disable iff (reset)
		(state_r == S_EXEC && target_r == T_BANK) |-> len_r == CYC_LD_BANK;
	endproperty
	a_len_bank: assert property (p_len_bank) else $error("bank load length");

	property p_len_page;
		@(posedge clk) disable iff (reset)
		(state_r == S_EXEC && (target_r == T_XPAGE || target_r == T_YPAGE ||
			target_r == T_GPAGE)) |-> len_r == CYC_LD_PAGE;
	endproperty
	a_len_page: assert property (p_len_page) else $error("page load length");

	property p_ypage_val;
		@(posedge clk) disable iff (reset)
		(state_r == S_EXEC && target_r == T_YPAGE) |=> regs_r.pageForY == $past(imm_r);
	endproperty
	a_ypage_val: assert property (p_ypage_val) else $error("y page not loaded");

	property p_gpage_val;
		@(posedge clk) disable iff (reset)
		(state_r == S_EXEC && target_r == T_GPAGE) |=> regs_r.generalDataPage == $past(imm_r);
	endproperty
	a_gpage_val: assert property (p_gpage_val) else $error("data page not loaded");

	c_stx: cover property (@(posedge clk) disable iff (reset) memWrite && target_r == T_NONE);
	c_ldr: cover property (@(posedge clk) disable iff (reset)
		state_r == S_EXEC && target_r == T_LDR);
	c_flags: cover property (@(posedge clk) disable iff (reset)
		state_r == S_EXEC && target_r == T_FLAGS);
	c_bad: cover property (@(posedge clk) disable iff (reset) illegalOp);
endmodule

// File: testbench/data_mem_model.sv
// data memory seen by the load-subset block: a write-only byte store keyed by page and address
// assumes the write strobe is a one-cycle registered pulse in the core clock domain
`timescale 1ns/1ns
module data_mem_model (
	input wire logic clk,
	input wire logic memWrite,
	input wire ld_subset_pkg::mem_write_s memOut
);
	import ld_subset_pkg::*;
	logic [7:0] mem [logic [23:0]];
	int writes = 0;

	// takes each strobe as it comes; the store never stalls the core, so no slow answer exists
	always @(posedge clk) begin
		if (memWrite === 1'b1) begin
			mem[{memOut.page, memOut.addr}] = memOut.data;
			writes++;
		end
	end
endmodule

// File: testbench/tb_load_instr_subset_exec.sv
// self-checking bench for the immediate-load and indexed-store decoder
// assumes one byte per fetch cycle and a data memory that always accepts writes
`timescale 1ns/1ns
module tb_load_instr_subset_exec;
	import ld_subset_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic largeMemoryModels = 1'b1;
	logic fetchValid = 1'b0;
	logic [7:0] fetchByte = 8'h00;
	logic fetchReady;
	logic memWrite;
	logic instrDone;
	logic illegalOp;
	mem_write_s memOut;
	core_regs_s regsOut;
	core_regs_s expRegs;
	int n_fail = 0;
	int cmp_count = 0;
	int cyc = 0;
	int t0;

	load_instr_subset_exec dut (.clk(clk), .reset(reset), .largeMemoryModels(largeMemoryModels),
		.fetchValid(fetchValid), .fetchByte(fetchByte), .fetchReady(fetchReady),
		.memWrite(memWrite), .memOut(memOut), .regsOut(regsOut), .instrDone(instrDone),
		.illegalOp(illegalOp));
	data_mem_model mem (.clk(clk), .memWrite(memWrite), .memOut(memOut));

	initial begin
		forever #25 clk = ~clk;
	end

	always @(posedge clk) cyc <= cyc + 1;

	task automatic summarize();
		if (n_fail == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chkRegs(input core_regs_s got, input core_regs_s exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// holds the byte until an edge sees ready high, then leaves valid up for the next byte
	task automatic sendByte(input logic [7:0] b);
		int n;
		fetchValid = 1'b1;
		fetchByte = b;
		for (n = 0; n < 16; n++) begin
			if (fetchReady === 1'b1) begin
				@(posedge clk);
				#1;
				return;
			end
			@(posedge clk);
			#1;
		end
		n_fail++;
		summarize();
	endtask

	// took counts edges from the opcode being taken to the edge that shows instrDone
	task automatic runInstr(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
		input int nb, output int took);
		int n;
		sendByte(b0);
		t0 = cyc;
		if (nb > 1) sendByte(b1);
		if (nb > 2) sendByte(b2);
		fetchValid = 1'b0;
		for (n = 0; n < 16; n++) begin
			@(posedge clk);
			#1;
			if (instrDone === 1'b1) break;
		end
		if (n == 16) begin
			n_fail++;
			summarize();
		end
		took = cyc - t0;
	endtask

	task automatic testReset();
		expRegs = '0;
		expRegs.systemFlags = RST_FLAGS;
		chkRegs(regsOut, expRegs);
		chkVal({fetchReady, memWrite, instrDone, illegalOp}, 4'b1000);
	endtask

	task automatic testRegLoads();
		int r;
		int took;
		logic [7:0] v;
		for (r = 0; r < 4; r++) begin
			v = 8'hA5 ^ 8'(r * 17);
			runInstr(OP_LD_R_IMM + 8'(r), v, 8'h00, 2, took);
			chkVal(took, CYC_LD_R);
			case (r)
				0: expRegs.regA = v;
				1: expRegs.regB = v;
				2: expRegs.regL = v;
				default: expRegs.regH = v;
			endcase
			chkRegs(regsOut, expRegs);
		end
	endtask

	task automatic testSpecialLoads();
		int took;
		runInstr(OP_LD_BASE, 8'h3C, 8'h00, 2, took);
		chkVal(took, CYC_LD_BASE);
		expRegs.baseHighByte = 8'h3C;
		chkRegs(regsOut, expRegs);
		runInstr(OP_PREFIX, OP_LD_FLAGS, 8'h3D, 3, took);
		chkVal(took, CYC_LD_FLAGS);
		expRegs.systemFlags = 8'h3D;
		chkRegs(regsOut, expRegs);
		runInstr(OP_PREFIX, OP_LD_BANK_P, 8'h96, 3, took);
		chkVal(took, CYC_LD_BANK);
		expRegs.newCodeBank = 8'h96;
		chkRegs(regsOut, expRegs);
		runInstr(OP_PREFIX, OP_LD_GPAGE_P, 8'h12, 3, took);
		chkVal(took, CYC_LD_PAGE);
		expRegs.generalDataPage = 8'h12;
		chkRegs(regsOut, expRegs);
		runInstr(OP_PREFIX, OP_LD_XPAGE_P, 8'h34, 3, took);
		chkVal(took, CYC_LD_PAGE);
		expRegs.pageForX = 8'h34;
		chkRegs(regsOut, expRegs);
		runInstr(OP_PREFIX, OP_LD_YPAGE_P, 8'h56, 3, took);
		chkVal(took, CYC_LD_PAGE);
		expRegs.pageForY = 8'h56;
		chkRegs(regsOut, expRegs);
	endtask

	// low byte alternates between the two ends of its signed range
	task automatic testStores();
		int m;
		int y;
		int s;
		int took;
		int w0;
		logic [7:0] lowv;
		logic [7:0] src;
		logic [7:0] pg;
		logic [15:0] ad;
		for (m = 0; m < 2; m++) begin
			largeMemoryModels = (m == 0);
			for (y = 0; y < 2; y++) begin
				for (s = 0; s < 4; s++) begin
					lowv = (s % 2) ? 8'h7F : 8'h80;
					runInstr(OP_LD_R_IMM + 8'h02, lowv, 8'h00, 2, took);
					expRegs.regL = lowv;
					case (s)
						0: src = expRegs.regA;
						1: src = expRegs.regB;
						2: src = expRegs.regL;
						default: src = expRegs.regH;
					endcase
					ad = (y ? expRegs.indexY : expRegs.indexX) + {{8{lowv[7]}}, lowv};
					pg = (m == 0) ? (y ? expRegs.pageForY : expRegs.pageForX) : 8'h00;
					w0 = mem.writes;
					runInstr(OP_PREFIX, OP_ST_X_LOW | 8'(y) | 8'(s << SRC_POS), 8'h00, 2, took);
					chkVal(took, CYC_ST_IDX);
					// the memory takes the strobe at the edge after it rises
					@(posedge clk);
					#1;
					chkVal(mem.writes - w0, 1);
					chkVal(memOut, {pg, ad, src});
					chkVal(mem.mem[{pg, ad}], src);
					chkRegs(regsOut, expRegs);
				end
			end
		end
	endtask

	// undecoded opcode, then an undecoded second byte after the prefix
	task automatic testIllegal();
		sendByte(8'h00);
		fetchValid = 1'b0;
		chkVal(illegalOp, 1'b1);
		sendByte(OP_PREFIX);
		sendByte(8'h00);
		fetchValid = 1'b0;
		chkVal({illegalOp, fetchReady}, 2'b11);
		chkRegs(regsOut, expRegs);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		summarize();
	end

	initial begin
		repeat (8) @(posedge clk);
		#1;
		reset = 1'b0;
		testReset();
		largeMemoryModels = 1'b1; // page loads only issued with large models on
		testRegLoads();
		testSpecialLoads();
		testStores();
		testIllegal();
		summarize();
	end
endmodule
